/* inc/scg_pkg.sv */
`default_nettype none
package scg_pkg;
   // ***********************************
   // widths and layout
   // ***********************************
   localparam int          GAIN_W    = 24;
   localparam int          DATA_W    = 24;
   localparam int          GAIN_FRAC = 22;
   localparam int          PROD_W    = 50;
   localparam int          CNT_W     = 5;
   localparam logic [4:0]  FRAME_BITS = 5'h18;
   localparam logic [23:0] GAIN_RST   = 24'h000000;
   localparam logic [23:0] SAT_MAX    = 24'h7FFFFF;
   localparam logic [23:0] SAT_MIN    = 24'h800000;
   localparam logic [49:0] ROUND_HALF = 50'h0000000200000;

   // ***********************************
   // serial frame states
   // ***********************************
   typedef enum logic [0:0] {
      SCG_IDLE  = 1'b0,
      SCG_SHIFT = 1'b1
   } scg_ser_state_t;
endpackage : scg_pkg
`default_nettype wire

/* inc/scg_corr_if.sv */
`default_nettype none
interface scg_corr_if;
   logic [23:0] raw;
   logic        raw_valid;
   logic [23:0] offset;
   logic [23:0] gain;
   logic        skip_off;
   logic        skip_gain;
   logic [23:0] res;
   logic        res_valid;

   modport src  (output raw, raw_valid, offset, gain, skip_off, skip_gain, input res, res_valid);
   modport corr (input raw, raw_valid, offset, gain, skip_off, skip_gain, output res, res_valid);
endinterface : scg_corr_if
`default_nettype wire

/* src/scg_corr.sv */
`default_nettype none
module scg_corr (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // correction path
   scg_corr_if.corr  cif
);
   // ***********************************
   // saturation
   // ***********************************
   function automatic logic [23:0] scg_sat(input logic signed [49:0] v);
      if (v > $signed({{26{1'b0}}, scg_pkg::SAT_MAX})) begin
         return scg_pkg::SAT_MAX;
      end else if (v < $signed({{26{1'b1}}, scg_pkg::SAT_MIN})) begin
         return scg_pkg::SAT_MIN;
      end else begin
         return v[23:0];
      end
   endfunction : scg_sat

   logic [23:0]        oc_q;
   logic               oc_vld_q;
   logic               skip_g_q;
   logic signed [49:0] diff;
   logic signed [49:0] prod;

   // ***********************************
   // stage 1: self offset
   // ***********************************
   assign diff = $signed({{26{cif.raw[23]}}, cif.raw}) - $signed({{26{cif.offset[23]}}, cif.offset});

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oc_q     <= scg_pkg::GAIN_RST;
         oc_vld_q <= 1'b0;
         skip_g_q <= 1'b0;
      end else begin
         oc_vld_q <= cif.raw_valid;
         skip_g_q <= cif.skip_gain;
         if (cif.raw_valid) begin
            oc_q <= cif.skip_off ? cif.raw : scg_sat(diff);
         end
      end
   end

   // ***********************************
   // stage 2: self gain, signed Q1.22
   // ***********************************
   // gain treated as signed, 0x400000 is unity, 0x7FFFFF just under 2x
   assign prod = $signed({{26{oc_q[23]}}, oc_q}) * $signed({{26{cif.gain[23]}}, cif.gain});

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cif.res       <= scg_pkg::GAIN_RST;
         cif.res_valid <= 1'b0;
      end else begin
         cif.res_valid <= oc_vld_q;
         if (oc_vld_q) begin
            // round to nearest keeps the error within one lsb
            cif.res <= skip_g_q ? oc_q
                     : scg_sat((prod + $signed(scg_pkg::ROUND_HALF)) >>> scg_pkg::GAIN_FRAC);
         end
      end
   end

   // ***********************************
   // checks
   // ***********************************
   sequence s_raw_in;
      cif.raw_valid ##1 oc_vld_q;
   endsequence

   a_path_latency: assert property (@(posedge clk) disable iff (rst)
      s_raw_in |=> cif.res_valid) else $error("result not two cycles after raw");
   a_skip_pass: assert property (@(posedge clk) disable iff (rst)
      oc_vld_q && skip_g_q |=> cif.res == $past(oc_q)) else $error("skipped gain altered result");
   a_offset_pass: assert property (@(posedge clk) disable iff (rst)
      cif.raw_valid && cif.skip_off |=> oc_q == $past(cif.raw)) else $error("skipped offset altered value");
   a_unity_gain: assert property (@(posedge clk) disable iff (rst)
      oc_vld_q && !skip_g_q && cif.gain == 24'h400000 |=> cif.res == $past(oc_q))
      else $error("unity gain changed result");
endmodule : scg_corr
`default_nettype wire

/* src/scg_top.sv */
`default_nettype none
// Behaviour
// - The self-cal gain register holds 24 bits that the host reads and writes.
// - Serial reads and writes of the gain register move the most significant bit first.
// - The gain value is always taken as a two's complement number.
// - A stored gain stays until the host rewrites it or a self-calibration stores its result.
// - Host writes arriving while a calibration is active are dropped and the value is kept.
// - Gain scaling is applied only while the skip-self-gain control bit is 0.
// - Scaling comes after self offset subtraction and before any system correction.
// - Scaling reaches up to two times, correcting about minus fifty percent gain error.
// - Residual gain error after scaling stays within two lsb.
// - With its skip bit at 0 the self offset is subtracted from the raw result before scaling.
module scg_top (
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   // serial pins
   input  wire logic        SER_CS_N,
   input  wire logic        SER_CLK,
   input  wire logic        SER_DIN,
   output logic             SER_DOUT,
   // command decoder, same clock
   input  wire logic        SER_SEL,
   input  wire logic        SER_WRITE,
   // self-calibration sequencer
   input  wire logic        CAL_ACTIVE,
   input  wire logic        CAL_GAIN_STORE,
   input  wire logic [23:0] CAL_GAIN_DATA,
   // control_reg_three bits and offset
   input  wire logic        SKIP_SELF_OFFSET_CORR,
   input  wire logic        SKIP_SELF_GAIN_CORR,
   input  wire logic [23:0] SELF_OFFSET_VALUE,
   // conversion path
   input  wire logic [23:0] RAW_DATA,
   input  wire logic        RAW_VALID,
   output logic      [23:0] COR_DATA,
   output logic             COR_VALID,
   // stored gain
   output logic      [23:0] GAIN_VALUE
);
   // ***********************************
   // pin synchronisers
   // ***********************************
   logic       cs_s1_q, cs_s2_q, cs_s3_q;
   logic       ck_s1_q, ck_s2_q, ck_s3_q;
   logic       di_s1_q, di_s2_q;
   logic       frame_start, frame_end, ser_rise;

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         di_s1_q <= 1'b0;
         di_s2_q <= 1'b0;
      end else begin
         cs_s1_q <= SER_CS_N;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         ck_s1_q <= SER_CLK;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         di_s1_q <= SER_DIN;
         di_s2_q <= di_s1_q;
      end
   end

   assign frame_start = cs_s3_q && !cs_s2_q;
   assign frame_end   = !cs_s3_q && cs_s2_q;
   assign ser_rise    = ck_s2_q && !ck_s3_q && !cs_s2_q;

   // ***********************************
   // serial frame
   // ***********************************
   scg_pkg::scg_ser_state_t state_q;
   logic [23:0]             shift_q;
   logic [4:0]              cnt_q;
   logic                    wr_q;
   logic                    commit;

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_q <= scg_pkg::SCG_IDLE;
      end else begin
         case (state_q)
            scg_pkg::SCG_IDLE: begin
               if (frame_start && SER_SEL) begin
                  state_q <= scg_pkg::SCG_SHIFT;
               end
            end
            scg_pkg::SCG_SHIFT: begin
               if (frame_end) begin
                  state_q <= scg_pkg::SCG_IDLE;
               end
            end
            default: begin
               state_q <= scg_pkg::SCG_IDLE;
            end
         endcase
      end
   end

   // read value loaded at frame start, then both directions msb first
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         shift_q <= scg_pkg::GAIN_RST;
         cnt_q   <= '0;
         wr_q    <= 1'b0;
      end else if (state_q == scg_pkg::SCG_IDLE && frame_start && SER_SEL) begin
         shift_q <= GAIN_VALUE;
         cnt_q   <= '0;
         wr_q    <= SER_WRITE;
      end else if (state_q == scg_pkg::SCG_SHIFT && ser_rise && cnt_q != scg_pkg::FRAME_BITS) begin
         shift_q <= {shift_q[22:0], di_s2_q};
         cnt_q   <= cnt_q + 5'h01;
      end
   end

   assign SER_DOUT = shift_q[23];

   // short frames never commit; an over-long frame commits its first 24 bits
   assign commit = state_q == scg_pkg::SCG_SHIFT && frame_end && wr_q && cnt_q == scg_pkg::FRAME_BITS;

   // ***********************************
   // gain register
   // ***********************************
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         GAIN_VALUE <= scg_pkg::GAIN_RST;
      end else if (CAL_GAIN_STORE) begin
         GAIN_VALUE <= CAL_GAIN_DATA;
      end else if (commit && !CAL_ACTIVE) begin
         GAIN_VALUE <= shift_q;
      end
   end

   // ***********************************
   // correction path
   // ***********************************
   scg_corr_if cif ();

   assign cif.raw       = RAW_DATA;
   assign cif.raw_valid = RAW_VALID;
   assign cif.offset    = SELF_OFFSET_VALUE;
   assign cif.gain      = GAIN_VALUE;
   assign cif.skip_off  = SKIP_SELF_OFFSET_CORR;
   assign cif.skip_gain = SKIP_SELF_GAIN_CORR;
   assign COR_DATA      = cif.res;
   assign COR_VALID     = cif.res_valid;

   scg_corr u_corr (
      .clk (REF_CLK),
      .rst (SYS_RST),
      .cif (cif.corr)
   );

   // ***********************************
   // checks
   // ***********************************
   sequence s_write_done;
      commit && !CAL_ACTIVE && !CAL_GAIN_STORE;
   endsequence

   a_host_write: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      s_write_done |=> GAIN_VALUE == $past(shift_q)) else $error("host write not stored");
   a_busy_drop: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      CAL_ACTIVE && !CAL_GAIN_STORE |=> $stable(GAIN_VALUE)) else $error("gain changed during calibration");
   a_cal_store: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      CAL_GAIN_STORE |=> GAIN_VALUE == $past(CAL_GAIN_DATA)) else $error("calibration result not stored");
   a_value_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      !CAL_GAIN_STORE && !commit |=> $stable(GAIN_VALUE)) else $error("gain changed without cause");
   a_msb_order: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      state_q == scg_pkg::SCG_SHIFT && ser_rise && cnt_q != scg_pkg::FRAME_BITS
      |=> SER_DOUT == $past(shift_q[22]) && shift_q[0] == $past(di_s2_q)) else $error("shift not msb first");
   a_read_load: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      state_q == scg_pkg::SCG_IDLE && frame_start && SER_SEL |=> SER_DOUT == $past(GAIN_VALUE[23]))
      else $error("read frame did not load msb");
endmodule : scg_top
`default_nettype wire

/* dv/scg_host_model.sv */
`default_nettype none
module scg_host_model (
   // clock
   input  wire logic clk,
   // serial pins
   output logic      cs_n,
   output logic      sclk,
   output logic      din,
   input  wire logic dout,
   // command decoder
   output logic      sel,
   output logic      wr_en
);
   timeunit 1ns;
   timeprecision 100ps;
   // bits per frame, shortened only to check that cut frames are dropped
   int n_bits = 24;
   initial begin
      cs_n  = 1'b1;
      sclk  = 1'b0;
      din   = 1'b0;
      sel   = 1'b0;
      wr_en = 1'b0;
   end
   // one 24-bit frame; four ref cycles per half period clears the synchronisers
   task automatic xfer(input logic wr, input logic [23:0] wdat, output logic [23:0] rdat);
      rdat = 24'h000000;
      @(negedge clk);
      cs_n  = 1'b0;
      sel   = 1'b1;
      wr_en = wr;
      repeat (6) @(negedge clk);
      for (int i = 23; i > 23 - n_bits; i--) begin
         din     = wdat[i];
         rdat[i] = dout;
         repeat (4) @(negedge clk);
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      sel  = 1'b0;
      // released line: no pull, so never leave the last bit standing
      din  = ~din;
      repeat (8) @(negedge clk);
   endtask : xfer
endmodule : scg_host_model
`default_nettype wire

/* dv/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0, rst = 1'b1, cs_n, sclk, din, dout, sel, wr_en;
   logic        cal_act = 1'b0, cal_st = 1'b0, skip_off = 1'b0, skip_gain = 1'b0, raw_vld = 1'b0, cor_vld;
   logic [23:0] cal_dat = 24'h000000, offs = 24'h000000, raw = 24'h000000, cor, gain, rd;
   int          n_fail = 0, n_tests = 0;

   always #12.5 clk = ~clk;

   scg_host_model host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .sel(sel), .wr_en(wr_en));
   scg_top dut_u (
      .REF_CLK(clk), .SYS_RST(rst), .SER_CS_N(cs_n), .SER_CLK(sclk), .SER_DIN(din), .SER_DOUT(dout),
      .SER_SEL(sel), .SER_WRITE(wr_en), .CAL_ACTIVE(cal_act), .CAL_GAIN_STORE(cal_st), .CAL_GAIN_DATA(cal_dat),
      .SKIP_SELF_OFFSET_CORR(skip_off), .SKIP_SELF_GAIN_CORR(skip_gain), .SELF_OFFSET_VALUE(offs),
      .RAW_DATA(raw), .RAW_VALID(raw_vld), .COR_DATA(cor), .COR_VALID(cor_vld), .GAIN_VALUE(gain));

   // ***********************************
   // shared tasks
   // ***********************************
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // valid pulse stands one cycle, seen two negedges after the strobe is set
   task automatic conv(input logic [23:0] v, input logic [23:0] exp);
      @(negedge clk);
      raw     = v;
      raw_vld = 1'b1;
      @(negedge clk);
      raw_vld = 1'b0;
      chk("cor_valid early", 24'h000000, {23'h0, cor_vld});
      @(negedge clk);
      chk("cor_valid", 24'h000001, {23'h0, cor_vld});
      chk("cor_data", exp, cor);
      @(negedge clk);
      chk("cor_valid late", 24'h000000, {23'h0, cor_vld});
   endtask : conv

   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_reset_and_rw();
      chk("gain after reset", 24'h000000, gain);
      host_u.xfer(1'b0, 24'h000000, rd);
      chk("read after reset", 24'h000000, rd);
      host_u.xfer(1'b1, 24'hA5C3F1, rd);
      chk("gain written", 24'hA5C3F1, gain);
      host_u.xfer(1'b0, 24'h000000, rd);
      chk("gain read back", 24'hA5C3F1, rd);
   endtask : t_reset_and_rw

   task automatic t_path();
      host_u.xfer(1'b1, 24'h400000, rd);
      offs = 24'h000100;
      conv(24'h001000, 24'h000F00);
      skip_off = 1'b1;
      conv(24'h001000, 24'h001000);
      skip_off  = 1'b0;
      skip_gain = 1'b1;
      host_u.xfer(1'b1, 24'h7FFFFF, rd);
      conv(24'h001000, 24'h000F00);
      skip_gain = 1'b0;
      conv(24'h001000, 24'h001E00);
      host_u.xfer(1'b1, 24'hC00000, rd);
      conv(24'h001000, 24'hFFF100);
   endtask : t_path

   task automatic t_cal();
      cal_act = 1'b1;
      host_u.xfer(1'b1, 24'h123456, rd);
      chk("gain during cal", 24'hC00000, gain);
      cal_act = 1'b0;
      cal_dat = 24'h3FFFFF;
      cal_st  = 1'b1;
      @(negedge clk);
      cal_st = 1'b0;
      @(negedge clk);
      chk("gain after store", 24'h3FFFFF, gain);
      host_u.xfer(1'b0, 24'h000000, rd);
      chk("stored gain read", 24'h3FFFFF, rd);
   endtask : t_cal

   // a write frame cut short must not commit
   task automatic t_short_frame();
      host_u.n_bits = 20;
      host_u.xfer(1'b1, 24'h0F0F0F, rd);
      host_u.n_bits = 24;
      chk("gain after short frame", 24'h3FFFFF, gain);
   endtask : t_short_frame

   // ***********************************
   // main sequence and watchdog
   // ***********************************
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_reset_and_rw();
      t_path();
      t_cal();
      t_short_frame();
      tally_and_finish();
   end

   // about ten frames of some 220 cycles each are expected
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
